// ==== testbench.sv ====
/*
 * Self-checking bench of the PWM timer channel, one task per scenario.
 * Assumes tpw_pkg, tpw_pwm and tpw_load_model are compiled first.
 */
`timescale 1ns/1ps
`include "tpw_defines.svh"
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end

module testbench;
    import tpw_pkg::*;
    logic        sys_clk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        trig_pin;
    logic        ovf;
    logic        pwm_pin;
    logic        pwm_oe;
    logic        irq;
    logic [1:0]  sub_cnt = 2'h0;
    logic        sub_tick;
    logic [15:0] rd_val;
    int          hi_len;
    int          per_len;
    int          falls;
    int          f;
    int          miscompares = 0;
    int          num_checks = 0;

    tpw_pwm dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_trigger_input_pin(trig_pin),
        .other_timer_overflow(ovf), .count_clock_subclock_div32(sub_tick),
        .timer_pulse_output_pin(pwm_pin), .pulse_output_enable(pwm_oe), .irq(irq));

    tpw_load_model load (.sys_clk(sys_clk), .pin(pwm_pin), .pin_en(pwm_oe), .hi_len(hi_len),
        .per_len(per_len), .falls(falls));

    // Sub-clock tick every fourth cycle
    always @(posedge sys_clk)
        sub_cnt <= sub_cnt + 2'h1;
    assign sub_tick = (sub_cnt == 2'h3);

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : rd

    task automatic waitf(input int k);
        int t;
        int i;
        t = falls + k;
        for (i = 0; i < 10000 && falls < t; i++)
            @(posedge sys_clk);
        #1;
        if (falls < t)
        begin
            miscompares++;
            $display("ERROR pulse fall count expected %0d seen %0d", t, falls);
            summarize();
        end
    endtask : waitf

    task automatic run(input logic [15:0] tv, input logic [7:0] mv, input int hi, input int per);
        wr(`TPW_OFS_TIMER, tv);
        wr(`TPW_OFS_MODE, {8'h00, mv});
        wr(`TPW_OFS_START, 16'h0001);
        waitf(3);
        `CHK("high width", hi, hi_len)
        `CHK("period", per, per_len)
    endtask : run

    // Started but waiting for its trigger: no pulses may appear
    task automatic arm(input logic [7:0] mv);
        wr(`TPW_OFS_START, 16'h0000);
        wr(`TPW_OFS_MODE, {8'h00, mv});
        wr(`TPW_OFS_START, 16'h0001);
        f = falls;
        tick(300);
        `CHK("armed falls", f, falls)
    endtask : arm

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`TPW_OFS_TIMER);
        `CHK("timer read", 16'hA5A5, rd_val)
        rd(`TPW_OFS_MODE);
        `CHK("mode reset", 16'h0000, rd_val)
        rd(`TPW_OFS_MASK);
        `CHK("mask reset", 16'h0000, rd_val)
        rd(8'h14);
        `CHK("unmapped read", 16'h0000, rd_val)
        rd(`TPW_OFS_STATUS);
        `CHK("pin level", 16'h0002, rd_val)
        `CHK("idle pin", 1'b0, pwm_pin)
        @(posedge sys_clk);
        trig_pin <= 1'b0;
    endtask : t_regs

    task automatic t_reload();
        run(16'h1001, 8'h11, 32, 510);
        `CHK("output enable", 1'b1, pwm_oe)
        waitf(1);
        wr(`TPW_OFS_TIMER, 16'h0801);
        waitf(2);
        `CHK("new width", 16, hi_len)
        `CHK("same period", 510, per_len)
    endtask : t_reload

    task automatic t_irq();
        wr(`TPW_OFS_MASK, 16'h0001);
        waitf(1);
        tick(3);
        `CHK("irq raised", 1'b1, irq)
        rd(`TPW_OFS_STATUS);
        `CHK("fall status", 1'b1, rd_val[0])
        wr(`TPW_OFS_STATUS, 16'h0001);
        tick(2);
        `CHK("irq cleared", 1'b0, irq)
        wr(`TPW_OFS_MASK, 16'h0000);
        waitf(1);
        tick(3);
        `CHK("irq masked", 1'b0, irq)
        rd(`TPW_OFS_STATUS);
        `CHK("masked status", 1'b1, rd_val[0])
        wr(`TPW_OFS_STATUS, 16'h0001);
    endtask : t_irq

    task automatic t_stop16();
        wr(`TPW_OFS_START, 16'h0000);
        tick(4);
        `CHK("stopped pin", 1'b0, pwm_pin)
        f = falls;
        tick(600);
        `CHK("no pulses", f, falls)
        // Full 16-bit period is too long to wait for; width only
        wr(`TPW_OFS_TIMER, 16'd100);
        wr(`TPW_OFS_MODE, 16'h0001);
        wr(`TPW_OFS_START, 16'h0001);
        waitf(1);
        `CHK("16-bit width", 100, hi_len)
        wr(`TPW_OFS_START, 16'h0000);
    endtask : t_stop16

    task automatic t_trig();
        arm(8'h17);
        @(posedge sys_clk);
        trig_pin <= 1'b1;
        waitf(3);
        `CHK("rise trig width", 4, hi_len)
        @(posedge sys_clk);
        trig_pin <= 1'b0;
        repeat (10) @(posedge sys_clk);
        trig_pin <= 1'b1;
        waitf(2);
        `CHK("width kept", 4, hi_len)
        `CHK("period kept", 255, per_len)
        arm(8'h15);
        @(posedge sys_clk);
        trig_pin <= 1'b0;
        waitf(2);
        `CHK("fall trig width", 4, hi_len)
        arm(8'h1D);
        @(posedge sys_clk);
        ovf <= 1'b1;
        @(posedge sys_clk);
        ovf <= 1'b0;
        waitf(2);
        `CHK("overflow start", 4, hi_len)
    endtask : t_trig

    // Divide-by-32 period is long, so width only; sub-clock gets both
    task automatic t_clk();
        wr(`TPW_OFS_START, 16'h0000);
        wr(`TPW_OFS_TIMER, 16'h0100);
        wr(`TPW_OFS_MODE, 16'h0091);
        wr(`TPW_OFS_START, 16'h0001);
        waitf(2);
        `CHK("div32 width", 32, hi_len)
        wr(`TPW_OFS_START, 16'h0000);
        run(16'h0201, 8'hD1, 16, 2040);
    endtask : t_clk

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        trig_pin = 1'b1;
        ovf = 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_reload();
        t_irq();
        t_stop16();
        run(16'h0400, 8'h51, 32, 2040);
        t_trig();
        t_clk();
        summarize();
    end
endmodule : testbench

// ==== tpw_defines.svh ====
/*
 * Register offsets, field positions, reset values and counts of the PWM timer channel.
 * Assumes inclusion by bare name from the testbench and the design module.
 */
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

// Register byte offsets
`define TPW_OFS_TIMER      8'h00
`define TPW_OFS_MODE       8'h04
`define TPW_OFS_START      8'h08
`define TPW_OFS_STATUS     8'h0C
`define TPW_OFS_MASK       8'h10

// Mode register fields
`define TPW_MODE_OUT_EN    0
`define TPW_MODE_EDGE      1
`define TPW_MODE_TRIG      2
`define TPW_MODE_EVSEL     3
`define TPW_MODE_WIDTH8    4
`define TPW_MODE_CLK_LO    6
`define TPW_MODE_CLK_HI    7

// Status fields
`define TPW_STAT_FALL      0
`define TPW_STAT_PIN       1

// Reset values
`define TPW_RST_MODE       8'h00
`define TPW_RST_TIMER      16'h0000
`define TPW_RST_MASK       1'b0

// Counts
`define TPW_PER16_LAST     16'hFFFE
`define TPW_PER8_LAST      16'h00FE
`define TPW_DIV8_LAST      3'h7
`define TPW_DIV32_LAST     5'h1F
`define TPW_UNDEF_READ     16'hA5A5

`endif

// ==== tpw_load_model.sv ====
/*
 * Load on the pulse output pin: measures high width and period in clock cycles.
 * Assumes the pin is sampled on sys_clk and pulled low while not driven.
 */
`timescale 1ns/1ps

module tpw_load_model
(
    input  wire logic sys_clk,
    input  wire logic pin,
    input  wire logic pin_en,
    output int        hi_len,
    output int        per_len,
    output int        falls
);
    logic seen;
    logic prev;
    int   hi_cnt;
    int   per_cnt;

    // Pull-down: an undriven pin reads low
    assign seen = pin & pin_en;

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        prev = 1'b0;
        hi_cnt = 0;
        per_cnt = 0;
        hi_len = 0;
        per_len = 0;
        falls = 0;
    end

    // First period value is partial, so callers skip it
    // Plain always, since the initial block also sets these
    always @(posedge sys_clk)
    begin
        prev <= seen;
        hi_cnt <= seen ? hi_cnt + 1 : 0;
        per_cnt <= (seen && !prev) ? 1 : per_cnt + 1;
        if (seen && !prev)
            per_len <= per_cnt;
        if (!seen && prev)
        begin
            hi_len <= hi_cnt;
            falls <= falls + 1;
        end
    end
endmodule : tpw_load_model

// ==== tpw_pkg.sv ====
/*
 * Types of the PWM timer channel.
 * Assumes tpw_defines.svh is on the include path.
 */
package tpw_pkg;

    typedef enum logic [1:0]
    {
        TPW_CLK_UNDIV  = 2'b00,
        TPW_CLK_DIV8   = 2'b01,
        TPW_CLK_DIV32  = 2'b10,
        TPW_CLK_SUB    = 2'b11
    } tpw_clk_sel_t;

    // Gray along idle, armed, run
    typedef enum logic [1:0]
    {
        TPW_IDLE  = 2'b00,
        TPW_ARMED = 2'b01,
        TPW_RUN   = 2'b11
    } tpw_state_t;

endpackage : tpw_pkg

// ==== tpw_pwm.sv ====
/*
 * Pulse width modulation channel of a down-counting timer, with register port and interrupt.
 * Assumes a single 40 MHz clock, a same-clock sub-clock tick and other-timer overflow pulse,
 * and an asynchronous trigger pin.
 */
// What this block does
// [RULE1] Down counter on selectable prescaled clock source
// [RULE2] Reload new count at each pulse rise
// [RULE3] Triggers during counting are ignored
// [RULE4] 16-bit: high n, period 65535 ticks
// [RULE5] 8-bit: high n times (m+1) ticks
// [RULE6] 8-bit: period 255 times (m+1) ticks
// [RULE7] Start on flag, or trigger when enabled
// [RULE8] Clearing start flag stops counting
// [RULE9] Input pin is GPIO or trigger
// [RULE10] Output pin drives successive pulses
// [RULE11] Timer register reads return undefined value
// [RULE12] Write when stopped loads reload and counter
// [RULE13] Write when counting loads reload only
// [RULE14] Pinless channels do not support PWM
// [RULE15] Edge bit: zero falling, one rising
// [RULE16] Trigger select: flag only or event source
// [RULE17] Bits 7:6 choose count clock source
// [RULE18] Interrupt when pulse falls each period
// [RULE19] Output low when stopped or low phase
`timescale 1ns/1ps
`include "tpw_defines.svh"

module tpw_pwm
    import tpw_pkg::*;
#(
    parameter bit HAS_PINS = 1'b1
)
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        timer_trigger_input_pin,
    input  wire logic        other_timer_overflow,
    input  wire logic        count_clock_subclock_div32,
    output logic             timer_pulse_output_pin,
    output logic             pulse_output_enable,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0]  reload_reg;
    logic [7:0]   mode_reg;
    logic         start_flag_reg;
    logic         fall_stat_reg;
    logic         mask_reg;
    logic [15:0]  rdata_reg;
    logic         irq_reg;
    logic         pulse_out_reg;
    logic         out_en_reg;
    tpw_state_t   state_reg;
    tpw_state_t   state_next;
    logic [4:0]   prescale_reg;
    logic [15:0]  pos_reg;
    logic [7:0]   pre_reg;
    logic [15:0]  n_cur_reg;
    logic [7:0]   m_cur_reg;
    logic         trig_s1_reg;
    logic         trig_s2_reg;
    logic         trig_s3_reg;
    logic         wr_timer;
    logic         wr_mode;
    logic         wr_start;
    logic         wr_status;
    logic         wr_mask;
    logic         mode8;
    logic         tick;
    logic         step;
    logic         period_end;
    logic         start_evt;
    logic [15:0]  period_last;
    logic [15:0]  elapsed;
    logic [15:0]  n_reload;
    logic         high_now;
    logic         fall_evt;
    logic         pin_rise;
    logic         pin_fall;
    logic         pin_edge;
    logic         trig_evt;
    tpw_clk_sel_t clk_sel;

    assign wr_timer  = reg_wr && (reg_addr == `TPW_OFS_TIMER);
    assign wr_mode   = reg_wr && (reg_addr == `TPW_OFS_MODE);
    assign wr_start  = reg_wr && (reg_addr == `TPW_OFS_START);
    assign wr_status = reg_wr && (reg_addr == `TPW_OFS_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == `TPW_OFS_MASK);
    assign mode8     = mode_reg[`TPW_MODE_WIDTH8];
    assign clk_sel   = tpw_clk_sel_t'(mode_reg[`TPW_MODE_CLK_HI:`TPW_MODE_CLK_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            reload_reg <= `TPW_RST_TIMER;
        else if (wr_timer)
            reload_reg <= reg_wdata; // [RULE12] [RULE13]
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            mode_reg <= `TPW_RST_MODE;
        else if (wr_mode)
            mode_reg <= reg_wdata[7:0];
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            start_flag_reg <= 1'b0;
        else if (wr_start)
            start_flag_reg <= reg_wdata[0]; // [RULE7] [RULE8]
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            mask_reg <= `TPW_RST_MASK;
        else if (wr_mask)
            mask_reg <= reg_wdata[`TPW_STAT_FALL];
    end
    // Count is not readable, so a constant hides it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_reg <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TPW_OFS_TIMER:  rdata_reg <= `TPW_UNDEF_READ; // [RULE11]
                `TPW_OFS_MODE:   rdata_reg <= {8'h00, mode_reg};
                `TPW_OFS_START:  rdata_reg <= {15'h0000, start_flag_reg};
                `TPW_OFS_STATUS: rdata_reg <= {14'h0000, trig_s2_reg, fall_stat_reg}; // [RULE9]
                `TPW_OFS_MASK:   rdata_reg <= {15'h0000, mask_reg};
                default:         rdata_reg <= 16'h0000;
            endcase
        end
        else
            rdata_reg <= 16'h0000;
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger pin synchroniser and event select
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
        end
        else
        begin
            trig_s1_reg <= timer_trigger_input_pin;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end
    assign pin_rise = trig_s2_reg && !trig_s3_reg;
    assign pin_fall = !trig_s2_reg && trig_s3_reg;
    assign pin_edge = mode_reg[`TPW_MODE_EDGE] ? pin_rise : pin_fall; // [RULE15]
    assign trig_evt = mode_reg[`TPW_MODE_EVSEL] ? other_timer_overflow : pin_edge; // [RULE7]

    ////////////////////////////////////////////////////////////////////////////
    // Count source
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            prescale_reg <= 5'h00;
        else
            prescale_reg <= prescale_reg + 5'h01;
    end
    always_comb
    begin
        case (clk_sel) // [RULE17] [RULE1]
            TPW_CLK_UNDIV: tick = 1'b1;
            TPW_CLK_DIV8:  tick = (prescale_reg[2:0] == `TPW_DIV8_LAST);
            TPW_CLK_DIV32: tick = (prescale_reg == `TPW_DIV32_LAST);
            TPW_CLK_SUB:   tick = count_clock_subclock_div32;
            default:       tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run control
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            TPW_IDLE:
                if (start_flag_reg)
                    state_next = mode_reg[`TPW_MODE_TRIG] ? TPW_ARMED : TPW_RUN; // [RULE16]
            TPW_ARMED:
                if (!start_flag_reg)
                    state_next = TPW_IDLE;
                else if (trig_evt)
                    state_next = TPW_RUN; // [RULE7]
            TPW_RUN:
                if (!start_flag_reg)
                    state_next = TPW_IDLE; // [RULE8] [RULE3]
            default:
                state_next = TPW_IDLE;
        endcase
        if (!HAS_PINS)
            state_next = TPW_IDLE; // [RULE14]
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= TPW_IDLE;
        else
            state_reg <= state_next;
    end
    assign start_evt = (state_reg != TPW_RUN) && (state_next == TPW_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Counter
    assign period_last = mode8 ? `TPW_PER8_LAST : `TPW_PER16_LAST; // [RULE4] [RULE6]
    assign step        = (state_reg == TPW_RUN) && tick && (!mode8 || (pre_reg == 8'h00)); // [RULE5]
    assign period_end  = step && (pos_reg == 16'h0000);
    assign n_reload    = mode8 ? {8'h00, reload_reg[15:8]} : reload_reg;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            pos_reg <= 16'h0000;
        else if (start_evt)
            pos_reg <= period_last;
        else if (step)
            pos_reg <= (pos_reg == 16'h0000) ? period_last : pos_reg - 16'h0001; // [RULE1] [RULE2]
    end
    // Prescaler gives m+1 ticks per 8-bit step
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            pre_reg <= 8'h00;
        else if (start_evt || period_end)
            pre_reg <= reload_reg[7:0];
        else if ((state_reg == TPW_RUN) && tick)
            pre_reg <= (pre_reg == 8'h00) ? m_cur_reg : pre_reg - 8'h01; // [RULE6]
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            n_cur_reg <= 16'h0000;
            m_cur_reg <= 8'h00;
        end
        else if (start_evt || period_end)
        begin
            n_cur_reg <= n_reload; // [RULE2] [RULE13]
            m_cur_reg <= reload_reg[7:0];
        end
        else if (wr_timer && (state_reg != TPW_RUN))
        begin
            n_cur_reg <= mode8 ? {8'h00, reg_wdata[15:8]} : reg_wdata; // [RULE12]
            m_cur_reg <= reg_wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse output and interrupt
    assign elapsed  = period_last - pos_reg;
    assign high_now = (state_reg == TPW_RUN) && (elapsed < n_cur_reg); // [RULE4] [RULE5] [RULE19]
    assign fall_evt = pulse_out_reg && !high_now && (state_reg == TPW_RUN);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pulse_out_reg <= 1'b0;
            out_en_reg    <= 1'b0;
        end
        else
        begin
            pulse_out_reg <= high_now; // [RULE10] [RULE19]
            out_en_reg    <= HAS_PINS && mode_reg[`TPW_MODE_OUT_EN];
        end
    end
    // Set wins over a same-cycle clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            fall_stat_reg <= 1'b0;
        else if (fall_evt)
            fall_stat_reg <= 1'b1; // [RULE18]
        else if (wr_status && reg_wdata[`TPW_STAT_FALL])
            fall_stat_reg <= 1'b0;
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= fall_stat_reg && mask_reg;
    end
    assign timer_pulse_output_pin = pulse_out_reg;
    assign pulse_output_enable    = out_en_reg;
    assign irq                    = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_soft_start;
        wr_start && reg_wdata[0] && !mode_reg[`TPW_MODE_TRIG] && state_reg == TPW_IDLE && !wr_mode;
    endsequence
    sequence s_stop;
        wr_start && !reg_wdata[0];
    endsequence

    property p_idle_low;
        (state_reg != TPW_RUN) |=> !timer_pulse_output_pin;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("pulse high while stopped"); // [RULE19]
    property p_stop;
        s_stop |=> ##1 (state_reg == TPW_IDLE) ##1 !timer_pulse_output_pin;
    endproperty
    a_stop: assert property (p_stop) else $error("clearing start flag did not stop"); // [RULE8]
    property p_soft_start;
        s_soft_start |=> ##1 (state_reg == TPW_RUN || !HAS_PINS);
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("software start did not run"); // [RULE7]
    property p_trig_ignored;
        (state_reg == TPW_RUN) && trig_evt && !step && start_flag_reg |=> $stable(pos_reg);
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("trigger disturbed counter"); // [RULE3]
    // Mask may change in the cycle after the fall; irq follows the old one
    property p_fall_irq;
        fall_evt |=> fall_stat_reg ##1 (irq == $past(mask_reg));
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("fall did not raise status"); // [RULE18]
    property p_write_stopped;
        wr_timer && state_reg == TPW_IDLE && !start_flag_reg |=>
            reload_reg == $past(reg_wdata) && m_cur_reg == $past(reg_wdata[7:0]);
    endproperty
    a_write_stopped: assert property (p_write_stopped) else $error("stopped write missed counter"); // [RULE12]
    property p_write_running;
        wr_timer && state_reg == TPW_RUN && !period_end |=> $stable(n_cur_reg) && $stable(m_cur_reg);
    endproperty
    a_write_running: assert property (p_write_running) else $error("running write reached counter"); // [RULE13]
    property p_read_undef;
        reg_rd && reg_addr == `TPW_OFS_TIMER |=> reg_rdata == `TPW_UNDEF_READ;
    endproperty
    a_read_undef: assert property (p_read_undef) else $error("timer read returned count"); // [RULE11]
    property p_reload;
        period_end |=> pos_reg == $past(period_last) && n_cur_reg == $past(n_reload);
    endproperty
    a_reload: assert property (p_reload) else $error("period end did not reload"); // [RULE2]
    property p_pinless;
        !HAS_PINS |-> state_reg == TPW_IDLE && !pulse_output_enable;
    endproperty
    a_pinless: assert property (p_pinless) else $error("pinless channel ran"); // [RULE14]

endmodule : tpw_pwm
